// file: dv/lsr_i2c_master.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bus master model
// ----------------------------------------
module lsr_i2c_master (
  input  wire ref_clk_i,
  input  wire sda_i,
  output reg  scl_o,
  output reg  sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Half of the 160 ns link period; the clock stands still between frames.
  task hp;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task start;
    hp;
    sda_o <= 1'b1;
    hp;
    scl_o <= 1'b1;
    hp;
    sda_o <= 1'b0;
    hp;
    scl_o <= 1'b0;
  endtask
  task stop;
    hp;
    sda_o <= 1'b0;
    hp;
    scl_o <= 1'b1;
    hp;
    sda_o <= 1'b1;
    hp;
  endtask
  // Data moves mid-way through the low phase, clear of both clock edges.
  task bit1(input b, output r);
    repeat (4) @(posedge ref_clk_i);
    sda_o <= b;
    repeat (4) @(posedge ref_clk_i);
    scl_o <= 1'b1;
    hp;
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task xfer(input [7:0] d, input a, output [7:0] q, output ak);
    reg r;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r);
      q[i] = r;
    end
    bit1(a, ak);
  endtask
endmodule // lsr_i2c_master

// file: dv/lsr_readout_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module lsr_readout_assertions #(
  parameter OSC_DIV = 305
) (
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe_o,
  input wire [15:0] broadband_current_i,
  input wire [15:0] compensation_current_i,
  input wire [7:0]  command_o,
  input wire        powered_down_o,
  input wire        conv_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sda_low: assert property (sda_oe_o |-> !sda_o) else $error("sda driven high");
  a_reset_vals: assert property (disable iff (1'b0) !rst_n_i |=> command_o == 8'h0C
    && !sda_oe_o && !conv_done_o && !powered_down_o) else $error("bad reset state");
  a_pdown_on: assert property ((command_o == 8'h8C) [*3] |-> powered_down_o)
    else $error("not powered down");
  a_pdown_off: assert property ((command_o != 8'h8C) [*3] |-> !powered_down_o)
    else $error("stray power down");
  a_pdown_quiet: assert property ((command_o == 8'h8C) [*3] |-> !conv_done_o)
    else $error("update while down");
  a_done_pulse: assert property (conv_done_o |=> !conv_done_o) else $error("long done");
  a_cmd_scl_low: assert property ($changed(command_o) |-> !scl_i)
    else $error("command moved with clock high");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved with clock high");
  a_ext_done: assert property ($changed(command_o) && (command_o == 8'h30 ||
    command_o == 8'h34 || command_o == 8'h38) |-> ##[0:2] conv_done_o)
    else $error("no update on external command");
endmodule // lsr_readout_assertions
bind lsr_readout lsr_readout_assertions #(.OSC_DIV(OSC_DIV)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .broadband_current_i(broadband_current_i),
  .compensation_current_i(compensation_current_i), .command_o(command_o),
  .powered_down_o(powered_down_o), .conv_done_o(conv_done_o));

// file: dv/lsr_readout_test.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bench
// ----------------------------------------
module lsr_readout_test;
  localparam DIV = 1;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [15:0] bb = 16'h1234;
  reg  [15:0] cp = 16'h0100;
  reg  [7:0]  cprev = 8'h0C;
  reg  [7:0]  q [0:3];
  reg         ak;
  wire        scl, m_sda, oe, sdo, pd, done;
  wire [7:0]  cmd;
  wire        sda = m_sda & (oe ? sdo : 1'b1);
  integer     mismatches = 0, n_checks = 0, cyc = 0, t_done = 0, t_prev = 0, t_cmd = 0, i, k;
  always #5 clk = ~clk;
  lsr_readout #(.OSC_DIV(DIV)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .broadband_current_i(bb),
    .compensation_current_i(cp), .command_o(cmd), .powered_down_o(pd), .conv_done_o(done));
  lsr_i2c_master u_m (.ref_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cprev <= cmd;
    if (cmd !== cprev) t_cmd <= cyc;
    if (done === 1'b1) begin
      t_prev <= t_done;
      t_done <= cyc;
    end
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g, input integer tol);
    n_checks = n_checks + 1;
    if (tol == 0 ? g !== e : (^g === 1'bx || g > e + tol || g + tol < e)) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [7:0] c, input full);
    u_m.start;
    u_m.xfer(8'h88, 1'b1, q[3], ak);
    chk("addr ack", 0, ak, 0);
    if (full) u_m.xfer(c, 1'b1, q[3], ak);
    if (full) chk("cmd ack", 0, ak, 0);
    u_m.stop;
  endtask
  task rd(input integer n);
    u_m.start;
    u_m.xfer(8'h89, 1'b1, q[3], ak);
    for (int j = 0; j < n; j++) u_m.xfer(8'hFF, j == n - 1, q[j], ak);
    u_m.stop;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("command", 16'h0C, cmd, 0);
    u_m.start;
    u_m.xfer(8'h8A, 1'b1, q[3], ak);
    u_m.stop;
    chk("foreign ack", 1, ak, 0);
    wr(8'h8C, 1);
    chk("command", 16'h8C, cmd, 0);
    chk("power down", 1, pd, 0);
    for (k = 0; k < 3; k++) begin
      wr(8'h30 + 4 * k, 1);
      wr(8'h30 + 4 * k, 1);
      rd(4);
      chk("result", k == 0 ? bb : k == 1 ? cp : bb - cp, {q[1], q[0]}, 0);
      chk("count", (t_done - t_prev) / DIV, {q[3], q[2]}, 2);
    end
    bb <= 16'h2000;
    wr(8'h00, 0);
    rd(4);
    chk("result", 16'h1F00, {q[1], q[0]}, 0);
    bb <= 16'h0777;
    wr(8'h00, 1);
    rd(2);
    chk("stale result", 16'h1F00, {q[1], q[0]}, 0);
    for (i = 0; i < 40000 && done !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    chk("period", 32768 * DIV, t_done - t_cmd, 8);
    rd(3);
    chk("result", 16'h0777, {q[1], q[0]}, 0);
    chk("third byte", 16'hFF, q[2], 0);
    wr(8'hA5, 1);
    rd(1);
    chk("test byte", 16'hA5, q[0], 0);
    wr(8'h0C, 1);
    rd(2);
    chk("reset result", 16'h0000, {q[1], q[0]}, 0);
    conclude;
  end
endmodule // lsr_readout_test

// file: rtl/lsr_consts.vh
// Contract
// - One 8-bit command register, held until rewritten.
// - Four readable bytes: result then count.
// - Fixed slave address 1000100 only.
// - Each write replaces command, acts at once.
// - No sub-addresses or register pointers.
// - Read order: result low, high, count low, high.
// - Result updates only when conversion completes; code also clears it on the reset command 0CH.
// - Address-only write re-executes held command.
// - Internal modes self-time each conversion.
// - External command ends and restarts integration.
// - 00H broadband, 04H compensation, unsigned, internal.
// - 08H signed difference, 200 ms internal.
// - 30H, 34H, 38H same conversions, externally timed.
// - 1xxx_xxxx command is readable bus test; code exempts 8CH, which powers down instead.
// - Difference: compensation first, then broadband.
// - Receiver pulls SDA low in acknowledge slot.
// - 16-bit oscillator counter latched at period end.
// - Internal modes: no acknowledge past two bytes.
// - Internal period is 32768 oscillator cycles; code gives that only first after a command, then 65536.
`ifndef LSR_CONSTS_VH
`define LSR_CONSTS_VH
`define LSR_SLAVE_ADDR 7'h44
`define LSR_CMD_RESET_VAL 8'h0C
`define LSR_CMD_PDOWN 8'h8C
`define LSR_CMD_RESET 8'h0C
`define LSR_CMD_BB_INT 8'h00
`define LSR_CMD_CP_INT 8'h04
`define LSR_CMD_DF_INT 8'h08
`define LSR_CMD_BB_EXT 8'h30
`define LSR_CMD_CP_EXT 8'h34
`define LSR_CMD_DF_EXT 8'h38
`define LSR_TEST_BIT 7
`define LSR_INT_PERIOD 16'h7FFF
`endif

// file: rtl/lsr_readout.v
`timescale 1ns/10ps
`include "lsr_consts.vh"
module lsr_readout #(
  parameter OSC_DIV = 305
) (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire [15:0] broadband_current_i,
  input  wire [15:0] compensation_current_i,
  output reg  [7:0]  command_o,
  output reg         powered_down_o,
  output reg         conv_done_o
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
// Two flip-flops per pin come before any decode reads them; a third stage
// keeps the previous sample for edge detection.
reg [1:0] scl_sync_q;
reg [1:0] sda_sync_q;
reg       scl_d1_q;
reg       sda_d1_q;
always @(posedge ref_clk_i) begin
  if (!rst_n_i) begin
    scl_sync_q <= 2'h3;
    sda_sync_q <= 2'h3;
    scl_d1_q   <= 1'b1;
    sda_d1_q   <= 1'b1;
  end else begin
    scl_sync_q <= {scl_sync_q[0], scl_i};
    sda_sync_q <= {sda_sync_q[0], sda_i};
    scl_d1_q   <= scl_sync_q[1];
    sda_d1_q   <= sda_sync_q[1];
  end
end
wire scl_s   = scl_sync_q[1];
wire sda_s   = sda_sync_q[1];
wire scl_ris = scl_s & ~scl_d1_q;
wire scl_fal = ~scl_s & scl_d1_q;
wire start_c = scl_s & scl_d1_q & ~sda_s & sda_d1_q;
wire stop_c  = scl_s & scl_d1_q & sda_s & ~sda_d1_q;
// A start or stop is only seen with SCL high on two samples in a row,
// so a glitch on SDA while SCL is low cannot open or close a frame.
// The price is about three reference clocks of lag behind the pins.

// ----------------------------------------------------------------
// Serial slave
// ----------------------------------------------------------------
// IDLE waits for a start, ADDR and WDAT shift in, RACK holds the
// address acknowledge of a read, RDAT shifts out.
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_WDAT = 3'h2;
localparam ST_RDAT = 3'h3;
localparam ST_RACK = 3'h4;

// Frame state. bit_q counts bits 0 to 7, 8 is the acknowledge slot and,
// on reads, 9 marks that slot as already sampled.
reg [2:0] st_q;
reg [3:0] bit_q;
reg [7:0] shift_q;
reg       ack_q;
reg       drive_q;
reg       rd_q;
reg [1:0] byte_q;
reg       got_cmd_q;
reg       addr_wr_q;
reg       exec_q;
// Data registers read back by the master; written at period end or cleared by the reset command.
reg [15:0] result_q;
reg [15:0] count_q;

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
// Decoding works on the held command, never on the byte in flight, so a
// half-received byte can never change the mode.
function is_ext;
  input [7:0] c;
  begin
    is_ext = (c == `LSR_CMD_BB_EXT) || (c == `LSR_CMD_CP_EXT) || (c == `LSR_CMD_DF_EXT);
  end
endfunction
function is_conv;
  input [7:0] c;
  begin
    is_conv = is_ext(c) || (c == `LSR_CMD_BB_INT) || (c == `LSR_CMD_CP_INT) ||
              (c == `LSR_CMD_DF_INT);
  end
endfunction

// Internally timed conversion commands.
function is_int;
  input [7:0] c;
  begin
    is_int = is_conv(c) && !is_ext(c);
  end
endfunction

// Two's-complement difference; it wraps on purpose so that a negative
// difference reads back as a signed 16-bit value.
function [15:0] diff16;
  input [15:0] a;
  input [15:0] b;
  begin
    diff16 = a - b;
  end
endfunction

// ----------------------------------------------------------------
// Read byte select
// ----------------------------------------------------------------
// Byte presented to the master on the n-th read byte. There is no
// pointer: every read starts again at the result low byte.
function [7:0] rd_byte;
  input [1:0] n;
  begin
    case (n)
      2'h0:    rd_byte = result_q[7:0];
      2'h1:    rd_byte = result_q[15:8];
      2'h2:    rd_byte = count_q[7:0];
      default: rd_byte = count_q[15:8];
    endcase
  end
endfunction

// Bus test echoes the command byte itself in place of the result, but
// only in the first byte; the power-down code also has its top bit set
// and is kept out so that it reads back the held data instead.
wire [7:0] tx_byte = command_o[`LSR_TEST_BIT] && (command_o != `LSR_CMD_PDOWN) ?
                     command_o : rd_byte(byte_q);

// ----------------------------------------------------------------
// Byte engine
// ----------------------------------------------------------------
// Start and stop win over any bit in progress, so a master that cuts a
// frame short always leaves the pin released and the engine idle, or in ADDR after a start.
always @(posedge ref_clk_i) begin
  if (!rst_n_i) begin
    st_q      <= ST_IDLE;
    bit_q     <= 4'h0;
    shift_q   <= 8'h00;
    ack_q     <= 1'b0;
    drive_q   <= 1'b0;
    rd_q      <= 1'b0;
    byte_q    <= 2'h0;
    got_cmd_q <= 1'b0;
    addr_wr_q <= 1'b0;
    exec_q    <= 1'b0;
    command_o <= `LSR_CMD_RESET_VAL;
  end else begin
    exec_q <= 1'b0;
    if (start_c) begin
      // A repeated start after an address-only write re-runs the command.
      if (addr_wr_q && !got_cmd_q)
        exec_q <= 1'b1;
      st_q      <= ST_ADDR;
      bit_q     <= 4'h0;
      ack_q     <= 1'b0;
      drive_q   <= 1'b0;
      addr_wr_q <= 1'b0;
      got_cmd_q <= 1'b0;
    end else if (stop_c) begin
      // A stop after an address-only write re-runs the command as well.
      if (addr_wr_q && !got_cmd_q)
        exec_q <= 1'b1;
      st_q      <= ST_IDLE;
      ack_q     <= 1'b0;
      drive_q   <= 1'b0;
      addr_wr_q <= 1'b0;
      got_cmd_q <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_WDAT: begin
          if (scl_ris && bit_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 4'h1;
          end
          if (scl_fal && bit_q == 4'h8) begin
            if (ack_q) begin
              ack_q <= 1'b0;
              bit_q <= 4'h0;
            end else if (st_q == ST_ADDR) begin
              if (shift_q[7:1] == `LSR_SLAVE_ADDR) begin
                ack_q  <= 1'b1;
                rd_q   <= shift_q[0];
                byte_q <= 2'h0;
                if (!shift_q[0])
                  addr_wr_q <= 1'b1;
                st_q <= shift_q[0] ? ST_RACK : ST_WDAT;
              end else begin
                st_q <= ST_IDLE;
              end
            end else begin
              // The command changes while SCL is low, so the new mode never
              // sees a half-sampled bit.
              command_o <= shift_q;
              got_cmd_q <= 1'b1;
              exec_q    <= 1'b1;
              ack_q     <= 1'b1;
            end
          end
        end
        ST_RACK: begin
          // Release address acknowledge and present first data bit on the same falling edge.
          if (scl_fal) begin
            ack_q   <= 1'b0;
            bit_q   <= 4'h0;
            shift_q <= tx_byte;
            drive_q <= 1'b1;
            st_q    <= ST_RDAT;
          end
        end
        ST_RDAT: begin
          if (scl_fal) begin
            if (bit_q < 4'h7) begin
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q   <= bit_q + 4'h1;
            end else if (bit_q == 4'h7) begin
              drive_q <= 1'b0;
              bit_q   <= 4'h8;
            end
          end
          if (scl_ris && bit_q == 4'h8) begin
            bit_q <= 4'h9;
            // Master acknowledge low means more bytes wanted.
            // A high is a refusal and ends the read at once.
            if (sda_s)
              st_q <= ST_IDLE;
          end
          if (scl_fal && bit_q == 4'h9) begin
            // Outside the externally timed modes no count is sent, so the engine lets go
            // of the pin after the result and the master reads ones.
            if ((byte_q == 2'h1 && !is_ext(command_o)) || byte_q == 2'h3) begin
              st_q <= ST_IDLE;
            end else begin
              byte_q  <= byte_q + 2'h1;
              bit_q   <= 4'h0;
              shift_q <= rd_byte(byte_q + 2'h1);
              drive_q <= 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end
end

// ----------------------------------------------------------------
// Pin drive
// ----------------------------------------------------------------
// The pin is open drain: only a low is ever driven, a one is sent by
// releasing it. Data goes out MSB first, an acknowledge pulls low.
assign sda_oe_o = ack_q | (drive_q & ~shift_q[7]);
assign sda_o    = 1'b0;

// ----------------------------------------------------------------
// Oscillator tick and conversion timing
// ----------------------------------------------------------------
reg [15:0] div_q;
reg [15:0] osc_cnt_q;
reg        phase_q;
reg [15:0] comp_q;
wire       osc_tick = (div_q == OSC_DIV[15:0] - 16'h1);
wire       int_end  = osc_tick && (osc_cnt_q == `LSR_INT_PERIOD);
// The counter starts from zero when a command runs, so the first terminal value is one
// less than the period length; after it the counter runs on and wraps.

always @(posedge ref_clk_i) begin
  if (!rst_n_i) begin
    div_q          <= 16'h0;
    osc_cnt_q      <= 16'h0;
    phase_q        <= 1'b0;
    comp_q         <= 16'h0;
    result_q       <= 16'h0;
    count_q        <= 16'h0;
    powered_down_o <= 1'b0;
    conv_done_o    <= 1'b0;
  end else begin
    conv_done_o    <= 1'b0;
    div_q          <= osc_tick ? 16'h0 : div_q + 16'h1;
    // Power down only stops conversions; the serial side keeps answering
    // so that the master can wake the converter with a new command.
    powered_down_o <= (command_o == `LSR_CMD_PDOWN);
    // A new conversion or reset command restarts the period; power down and bus test
    // leave it alone, and an external command first closes the running integration.
    if (exec_q && command_o == `LSR_CMD_RESET) begin
      osc_cnt_q <= 16'h0;
      phase_q   <= 1'b0;
      result_q  <= 16'h0;
      count_q   <= 16'h0;
    end else if (exec_q && is_ext(command_o)) begin
      // Externally timed: close the running integration, open a new one.
      count_q   <= osc_cnt_q;
      osc_cnt_q <= 16'h0;
      phase_q   <= 1'b0;
      case (command_o)
        `LSR_CMD_BB_EXT: result_q <= broadband_current_i;
        `LSR_CMD_CP_EXT: result_q <= compensation_current_i;
        default:         result_q <= diff16(broadband_current_i, compensation_current_i);
      endcase
      conv_done_o <= 1'b1;
    end else if (exec_q && is_conv(command_o)) begin
      osc_cnt_q <= 16'h0;
      phase_q   <= 1'b0;
    end else if (osc_tick && is_int(command_o)) begin
      // Internally timed: the period ends on the terminal count and the
      // held result stays readable until then.
      osc_cnt_q <= osc_cnt_q + 16'h1;
      if (int_end) begin
        // Difference mode spends a first full period on the compensation
        // diode; the counter then runs a full 65536-tick wrap, so its result comes after three times the period.
        if (command_o == `LSR_CMD_DF_INT && !phase_q) begin
          comp_q  <= compensation_current_i;
          phase_q <= 1'b1;
        end else begin
          phase_q     <= 1'b0;
          count_q     <= osc_cnt_q;
          conv_done_o <= 1'b1;
          case (command_o)
            `LSR_CMD_BB_INT: result_q <= broadband_current_i;
            `LSR_CMD_CP_INT: result_q <= compensation_current_i;
            default:         result_q <= diff16(broadband_current_i, comp_q);
          endcase
        end
      end
    end else if (osc_tick && is_ext(command_o)) begin
      // Wraps past 65535; the master keeps periods short enough.
      osc_cnt_q <= osc_cnt_q + 16'h1;
    end
  end
end

endmodule // lsr_readout
